// file: flash_cmd_device.sv
// Flash end: decodes resume, sleep, wake/identify, read parameters
// and identification commands from the serial link.
// Assumes the link is slow against mclk (sck period >= 8 mclk).
//
// How it works
// (RULE1) Resume restarts operation, clears suspend flags
// (RULE2) Quad mode: two nibbles, high first
// (RULE3) Host polls busy flag or waits write time
// (RULE4) Resumed write time never exceeds uninterrupted
// (RULE5) Sleep only on select rise after opcode
// (RULE6) Sleep reached within entry delay
// (RULE7) Asleep: only wake opcode recognised
// (RULE8) Host holds select high during wake recovery
// (RULE9) Wake opcode ignored while write in progress
// (RULE10) Set parameters writes drive strength, reset half
// (RULE11) Parameter values 04h-07h pick 8-64 byte wrap
// (RULE12) Wrap read stays inside aligned burst
// (RULE13) No wrap: address increments across array
// (RULE14) Wrap persists until cleared, sleep or reset
// (RULE15) Every read uses wrap addressing when enabled
// (RULE16) Legacy identify: three dummies, device code repeats
// (RULE17) Standard identify: maker then type-density code
// (RULE18) Standard identify repeats three bytes cyclically
// (RULE19) Maker/device read order chosen by address bit0
// (RULE20) Maker/device codes alternate while clocked
// (RULE21) Program suspend bit2, erase suspend bit3
// (RULE22) Write-in-progress high while write runs
// (RULE23) Partial commands discarded on select rise
`timescale 1ns/1ns
`include "flash_cmd_consts.svh"
module flash_cmd_device import flash_cmd_pkg::*; #(
	parameter logic [7:0]  MAKER_CODE  = 8'h5A, // arbitrary value
	parameter logic [7:0]  DEVICE_CODE = 8'h3C, // arbitrary value
	parameter logic [15:0] TYPE_CODE   = 16'hA5C3 // arbitrary value
)(
	// System
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Link
	flash_link_if.device     link,
	// Mode and write engine
	input  wire logic        quadMode,
	input  wire logic        writeInProgressFlag,
	input  wire logic        suspendProgram,
	input  wire logic        suspendErase,
	output logic             resumeRequest,
	output logic [3:0]       functionBits,
	output logic             lowPower,
	// Read parameters
	output logic [2:0]       driveStrength,
	output logic             wrapEnable,
	output logic [1:0]       burstSize,
	// Read address sequencer
	input  wire logic        addrLoad,
	input  wire logic [23:0] addrLoadValue,
	input  wire logic        addrStep,
	output logic [23:0]      readAddr
);
	////////////////////////////////////////////////////////////////
	function automatic logic [3:0] stepBits(input logic [3:0] bits,
		input logic quad);
		return bits + (quad ? `STEP_QUAD : `STEP_SPI);
	endfunction

	function automatic logic [7:0] idByte(input logic [7:0] op,
		input logic [1:0] idx, input logic a0);
		logic [7:0] b;
		b = MAKER_CODE;
		case (op)
			`OP_WAKE_ID:      b = DEVICE_CODE;
			// (RULE19) address bit 0 picks the first code
			`OP_MAKER_DEV_ID: b = (idx[0] ^ a0) ? DEVICE_CODE : MAKER_CODE;
			default: begin
				if (idx == 2'd1)
					b = TYPE_CODE[15:8];
				else if (idx == `STD_ID_LAST)
					b = TYPE_CODE[7:0];
			end
		endcase
		return b;
	endfunction

	function automatic logic [23:0] nextReadAddr(input logic [23:0] a,
		input logic wrap, input logic [1:0] size);
		logic [23:0] mask;
		mask = wrap ? ((`BURST_MIN_BYTES << size) - 24'h00_0001) : '1;
		return (a & ~mask) | ((a + 24'h00_0001) & mask);
	endfunction

	////////////////////////////////////////////////////////////////
	// Link synchroniser: {io, csN, sck}
	logic [5:0] syncA, syncB, syncPrev;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			syncA    <= `SYNC_RESET;
			syncB    <= `SYNC_RESET;
			syncPrev <= `SYNC_RESET;
		end else begin
			syncA    <= {link.io, link.csN, link.sck};
			syncB    <= syncA;
			syncPrev <= syncB;
		end
	end

	wire       sckRise = syncB[0] & ~syncPrev[0];
	wire       sckFall = ~syncB[0] & syncPrev[0];
	wire       csHigh  = syncB[1];
	wire       csRise  = syncB[1] & ~syncPrev[1];
	wire [3:0] ioIn    = syncB[5:2];

	////////////////////////////////////////////////////////////////
	// Command capture
	cmd_state_t state;
	pwr_state_t pwrState;
	logic [3:0] rxBits;
	logic [7:0] rxByte, opcode, argLast;
	logic [1:0] argLeft;
	logic [7:0] next_rxByte;
	logic [3:0] next_rxBits;

	// (RULE2) high nibble first
	assign next_rxByte = quadMode ? {rxByte[3:0], ioIn}
		: {rxByte[6:0], ioIn[0]};
	assign next_rxBits = stepBits(rxBits, quadMode);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state   <= CMD_OPCODE;
			rxBits  <= 4'h0;
			rxByte  <= 8'h00;
			opcode  <= 8'h00;
			argLast <= 8'h00;
			argLeft <= 2'd0;
		end else if (csHigh) begin
			// (RULE23) drop partial command
			state  <= CMD_OPCODE;
			rxBits <= 4'h0;
		end else if (sckRise && (state == CMD_OPCODE || state == CMD_ARGS)) begin
			rxByte <= next_rxByte;
			rxBits <= next_rxBits[3] ? 4'h0 : next_rxBits;
			if (next_rxBits[3] && state == CMD_OPCODE) begin
				opcode <= next_rxByte;
				state  <= CMD_SKIP;
				if (pwrState == PWR_ASLEEP) begin
					// (RULE7) only wake while asleep
					// (RULE22) busy flag from the write engine
					if (next_rxByte == `OP_WAKE_ID && !writeInProgressFlag)
						state <= CMD_DONE;
				end else if (pwrState == PWR_AWAKE) begin
					case (next_rxByte)
						`OP_RESUME, `OP_SLEEP: state <= CMD_DONE;
						`OP_SET_PARAMS: begin
							state   <= CMD_ARGS;
							argLeft <= `SET_PARAMS_ARGS;
						end
						// (RULE9) ignored during write
						`OP_WAKE_ID: if (!writeInProgressFlag) begin
							state   <= CMD_ARGS;
							argLeft <= `LEGACY_ID_ARGS;
						end
						`OP_MAKER_DEV_ID: begin
							state   <= CMD_ARGS;
							argLeft <= `MAKER_DEV_ARGS;
						end
						default: begin
							// (RULE17) mode picks identify opcode
							if (next_rxByte == (quadMode ? `OP_STD_ID_QUAD
								: `OP_STD_ID_SPI))
								state <= CMD_OUT;
						end
					endcase
				end
			end else if (next_rxBits[3]) begin
				argLeft <= argLeft - 2'd1;
				argLast <= next_rxByte;
				if (argLeft == 2'd1)
					state <= (opcode == `OP_SET_PARAMS) ? CMD_DONE : CMD_OUT;
			end
		end
	end

	// (RULE5) act only on a complete command at select rise
	wire execNow = csRise && state == CMD_DONE;

	////////////////////////////////////////////////////////////////
	// Identification output, shifted on falling sck
	logic [3:0] txBits;
	logic [1:0] txIdx;
	logic [3:0] next_txBits;
	logic [7:0] curByte;
	assign next_txBits = stepBits(txBits, quadMode);
	assign curByte     = idByte(opcode, txIdx, argLast[0]);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			txBits     <= 4'h0;
			txIdx      <= 2'd0;
			link.devIo <= `IO_IDLE;
			link.devOe <= `OE_NONE;
		end else if (csHigh) begin
			txBits     <= 4'h0;
			txIdx      <= 2'd0;
			link.devOe <= `OE_NONE;
		end else if (sckFall && state == CMD_OUT) begin
			link.devOe <= quadMode ? `OE_QUAD : `OE_SPI_OUT;
			link.devIo <= quadMode
				? (txBits[2] ? curByte[3:0] : curByte[7:4])
				: {2'b11, curByte[3'd7 - txBits[2:0]], 1'b1};
			if (next_txBits[3]) begin
				txBits <= 4'h0;
				// (RULE18) three-byte loop for standard identify
				// (RULE16) (RULE20) others repeat or alternate
				if (opcode != `OP_WAKE_ID && opcode != `OP_MAKER_DEV_ID
					&& txIdx == `STD_ID_LAST)
					txIdx <= 2'd0;
				else
					txIdx <= txIdx + 2'd1;
			end else
				txBits <= next_txBits;
		end
	end

	////////////////////////////////////////////////////////////////
	// Power state
	logic [11:0] pwrCnt;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pwrState <= PWR_AWAKE;
			pwrCnt   <= 12'h000;
			lowPower <= 1'b0;
		end else begin
			lowPower <= (pwrState == PWR_ASLEEP);
			case (pwrState)
				PWR_AWAKE: if (execNow && opcode == `OP_SLEEP) begin
					pwrState <= PWR_ENTERING;
					// Synchroniser lag already eats part of the delay
					pwrCnt   <= 12'(`SLEEP_ENTRY_CYCLES - `SYNC_LAG_CYCLES);
				end
				// (RULE6) asleep within the entry delay
				PWR_ENTERING: begin
					pwrCnt <= pwrCnt - 12'h001;
					if (pwrCnt == 12'h000)
						pwrState <= PWR_ASLEEP;
				end
				PWR_ASLEEP: if (execNow) begin
					pwrState <= PWR_WAKING;
					pwrCnt   <= 12'(`WAKE_RECOVERY_CYCLES - 1);
				end
				PWR_WAKING: begin
					pwrCnt <= pwrCnt - 12'h001;
					if (pwrCnt == 12'h000)
						pwrState <= PWR_AWAKE;
				end
				default: pwrState <= PWR_AWAKE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Read parameters
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			// (RULE10) half drive after reset
			driveStrength <= `DRIVE_RESET;
			wrapEnable    <= 1'b0;
			burstSize     <= 2'd0;
		end else if (execNow && pwrState == PWR_AWAKE) begin
			// (RULE10) (RULE11) drive and burst fields
			if (opcode == `OP_SET_PARAMS) begin
				driveStrength <= argLast[`PARAM_DRV_MSB:`PARAM_DRV_LSB];
				wrapEnable    <= argLast[`PARAM_WRAP];
				burstSize     <= argLast[`PARAM_SIZE_MSB:`PARAM_SIZE_LSB];
			end
			// (RULE14) sleep drops wrap mode
			if (opcode == `OP_SLEEP)
				wrapEnable <= 1'b0;
		end
	end

	// (RULE12) (RULE13) (RULE15) one sequencer for every read
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			readAddr <= 24'h00_0000;
		else if (addrLoad)
			readAddr <= addrLoadValue;
		else if (addrStep)
			readAddr <= nextReadAddr(readAddr, wrapEnable, burstSize);
	end

	////////////////////////////////////////////////////////////////
	// Suspend flags; a suspend arriving with resume wins
	wire resumeNow = execNow && pwrState == PWR_AWAKE
		&& opcode == `OP_RESUME;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			resumeRequest <= 1'b0;
			functionBits  <= 4'h0;
		end else begin
			// (RULE4) engine continues its remaining time only
			resumeRequest <= resumeNow;
			// (RULE21) (RULE1) bit2 program, bit3 erase
			if (suspendProgram)
				functionBits[2] <= 1'b1;
			else if (resumeNow)
				functionBits[2] <= 1'b0;
			if (suspendErase)
				functionBits[3] <= 1'b1;
			else if (resumeNow)
				functionBits[3] <= 1'b0;
		end
	end
endmodule

// file: flash_cmd_consts.svh
// Constants shared by both ends of the flash command link.
// Assumes a 20 MHz mclk on both ends.
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

// Opcodes
`define OP_RESUME        8'h30
`define OP_SLEEP         8'hB9
`define OP_WAKE_ID       8'hAB
`define OP_SET_PARAMS    8'hC0
`define OP_STD_ID_SPI    8'h9F
`define OP_STD_ID_QUAD   8'hAF
`define OP_MAKER_DEV_ID  8'h90

// Argument bytes after the opcode; last standard identify byte index
`define SET_PARAMS_ARGS  2'd1
`define LEGACY_ID_ARGS   2'd3
`define MAKER_DEV_ARGS   2'd3
`define STD_ID_LAST      2'd2

// Read parameter byte layout
`define PARAM_SIZE_LSB   0
`define PARAM_SIZE_MSB   1
`define PARAM_WRAP       2
`define PARAM_DRV_LSB    5
`define PARAM_DRV_MSB    7
`define DRIVE_RESET      3'h3
`define BURST_MIN_BYTES  24'h00_0008

// Link bit steps and resets
`define STEP_SPI         4'h1
`define STEP_QUAD        4'h4
`define OE_SPI_OUT       4'h2
`define OE_SPI_IN        4'h1
`define OE_QUAD          4'hF
`define OE_NONE          4'h0
`define SYNC_RESET       6'h3E
`define IO_IDLE          4'hF

// Timing
`define MCLK_PERIOD_NS   50
`define SLEEP_ENTRY_NS   3000
`define WAKE_RECOVERY_NS 5000
`define SLEEP_ENTRY_CYCLES (`SLEEP_ENTRY_NS / `MCLK_PERIOD_NS)
`define WAKE_RECOVERY_CYCLES \
	((`WAKE_RECOVERY_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define SCK_HALF_CYCLES  4
`define HOST_GAP_CYCLES  4
// Select rise to device action, with margin for the synchroniser
`define SYNC_LAG_CYCLES  6

`endif

// file: flash_cmd_pkg.sv
// Types shared by both ends of the flash command link.
// Assumes flash_cmd_consts.svh for the numeric constants.
package flash_cmd_pkg;
	typedef enum logic [3:0] {
		PWR_AWAKE    = 4'b0001,
		PWR_ENTERING = 4'b0010,
		PWR_ASLEEP   = 4'b0100,
		PWR_WAKING   = 4'b1000
	} pwr_state_t;

	typedef enum logic [4:0] {
		CMD_OPCODE = 5'b00001,
		CMD_ARGS   = 5'b00010,
		CMD_OUT    = 5'b00100,
		CMD_DONE   = 5'b01000,
		CMD_SKIP   = 5'b10000
	} cmd_state_t;

	typedef enum logic [2:0] {
		HOST_IDLE  = 3'b001,
		HOST_SHIFT = 3'b010,
		HOST_GAP   = 3'b100
	} host_state_t;
endpackage

// file: flash_link_if.sv
// Serial flash link: clock, select and four data lines.
// Each line resolves from the enables; undriven lines float high.
`timescale 1ns/1ns
interface flash_link_if;
	logic       sck;
	logic       csN;
	logic [3:0] hostIo;
	logic [3:0] hostOe;
	logic [3:0] devIo;
	logic [3:0] devOe;
	logic [3:0] io;

	genvar i;
	for (i = 0; i < 4; i++) begin : g_line
		assign io[i] = devOe[i] ? devIo[i] : (hostOe[i] ? hostIo[i] : 1'b1);
	end

	modport device (input sck, input csN, input io,
		output devIo, output devOe);
	modport host (output sck, output csN, output hostIo, output hostOe,
		input io);
endinterface

// file: flash_cmd_host.sv
// Host end: sends one command, optional argument bytes, and reads
// back a number of bytes. Drives sck from mclk by a divider.
// Assumes the user waits for cmdDone before the next cmdStart.
`timescale 1ns/1ns
`include "flash_cmd_consts.svh"
module flash_cmd_host import flash_cmd_pkg::*; #(
	parameter int SCK_HALF = `SCK_HALF_CYCLES
)(
	// System
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Link
	flash_link_if.host       link,
	// Command request
	input  wire logic        quadMode,
	input  wire logic        cmdStart,
	input  wire logic [7:0]  cmdOpcode,
	input  wire logic [1:0]  cmdArgCount,
	input  wire logic [23:0] cmdArgs,
	input  wire logic [2:0]  cmdReadCount,
	// Answer
	output logic             busy,
	output logic [7:0]       rxData,
	output logic             rxValid,
	output logic             cmdDone
);
	////////////////////////////////////////////////////////////////
	logic [3:0] ioA, ioB;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ioA <= `IO_IDLE;
			ioB <= `IO_IDLE;
		end else begin
			ioA <= link.io;
			ioB <= ioA;
		end
	end

	////////////////////////////////////////////////////////////////
	host_state_t state;
	logic [3:0]  divCnt;
	logic [6:0]  per, totalPer, txPer;
	logic [31:0] txShift;
	logic [7:0]  rxShift;
	logic [3:0]  rxCnt;
	logic [11:0] gapCnt;
	logic        wakeGap;
	logic [3:0]  step;
	logic [6:0]  next_per;
	assign step     = quadMode ? `STEP_QUAD : `STEP_SPI;
	assign next_per = per + 7'd1;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state       <= HOST_IDLE;
			divCnt      <= 4'h0;
			per         <= 7'd0;
			totalPer    <= 7'd0;
			txPer       <= 7'd0;
			txShift     <= 32'h0000_0000;
			rxShift     <= 8'h00;
			rxCnt       <= 4'h0;
			gapCnt      <= 12'h000;
			wakeGap     <= 1'b0;
			busy        <= 1'b0;
			rxData      <= 8'h00;
			rxValid     <= 1'b0;
			cmdDone     <= 1'b0;
			link.sck    <= 1'b0;
			link.csN    <= 1'b1;
			link.hostIo <= `IO_IDLE;
			link.hostOe <= `OE_NONE;
		end else begin
			rxValid <= 1'b0;
			cmdDone <= 1'b0;
			case (state)
				HOST_IDLE: if (cmdStart) begin
					state    <= HOST_SHIFT;
					busy     <= 1'b1;
					divCnt   <= 4'h0;
					per      <= 7'd0;
					rxCnt    <= 4'h0;
					// (RULE2) bytes cut into high-first nibbles
					txPer    <= quadMode ? {4'd0, cmdArgCount, 1'b0} + 7'd2
						: {1'b0, cmdArgCount, 3'd0} + 7'd8;
					totalPer <= quadMode
						? 7'({cmdArgCount, 1'b0} + {cmdReadCount, 1'b0}) + 7'd2
						: 7'({cmdArgCount, 3'd0} + {cmdReadCount, 3'd0}) + 7'd8;
					txShift  <= quadMode ? {cmdOpcode, cmdArgs} << 4
						: {cmdOpcode, cmdArgs} << 1;
					wakeGap  <= cmdOpcode == `OP_WAKE_ID && cmdArgCount == 2'd0;
					link.csN    <= 1'b0;
					link.hostIo <= quadMode ? cmdOpcode[7:4]
						: {3'b111, cmdOpcode[7]};
					link.hostOe <= quadMode ? `OE_QUAD : `OE_SPI_IN;
				end
				HOST_SHIFT: if (divCnt == 4'(SCK_HALF - 1)) begin
					divCnt <= 4'h0;
					if (!link.sck)
						link.sck <= 1'b1;
					else begin
						link.sck <= 1'b0;
						per      <= next_per;
						if (per >= txPer) begin
							rxShift <= quadMode ? {rxShift[3:0], ioB}
								: {rxShift[6:0], ioB[1]};
							rxCnt <= (rxCnt + step) & 4'h7;
							if (rxCnt + step == 4'h8) begin
								rxData  <= quadMode ? {rxShift[3:0], ioB}
									: {rxShift[6:0], ioB[1]};
								rxValid <= 1'b1;
							end
						end
						if (next_per == totalPer) begin
							state       <= HOST_GAP;
							link.csN    <= 1'b1;
							link.hostOe <= `OE_NONE;
							// (RULE8) hold select high through wake recovery
							// Device counts from a late, synchronised rise
							gapCnt <= wakeGap
								? 12'(`WAKE_RECOVERY_CYCLES + `SYNC_LAG_CYCLES)
								: 12'(`HOST_GAP_CYCLES);
						end else if (next_per >= txPer)
							link.hostOe <= `OE_NONE;
						else begin
							link.hostIo <= quadMode ? txShift[31:28]
								: {3'b111, txShift[31]};
							txShift <= txShift << step;
						end
					end
				end else
					divCnt <= divCnt + 4'h1;
				HOST_GAP: begin
					gapCnt <= gapCnt - 12'h001;
					if (gapCnt == 12'h001) begin
						state   <= HOST_IDLE;
						busy    <= 1'b0;
						cmdDone <= 1'b1;
					end
				end
				default: state <= HOST_IDLE;
			endcase
		end
	end
endmodule

// file: flash_cmd_chk.sv
// Checker on the flash link and the device status lines.
// Instantiated beside the link interface; sees plain signals only.
`timescale 1ns/1ns
`include "flash_cmd_consts.svh"
module flash_cmd_chk (
	// System
	input wire logic       mclk,
	input wire logic       arst_n,
	// Link
	input wire logic       sck,
	input wire logic       csN,
	input wire logic [3:0] hostOe,
	input wire logic [3:0] devOe,
	// Device status
	input wire logic       writeInProgressFlag,
	input wire logic       resumeRequest,
	input wire logic       lowPower,
	input wire logic       wrapEnable,
	input wire logic [2:0] driveStrength
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// Cycles since select went high, saturating
	logic [7:0] riseCnt;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			riseCnt <= 8'hFF;
		else if (!csN)
			riseCnt <= 8'h00;
		else if (riseCnt != 8'hFF)
			riseCnt <= riseCnt + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////
	AST_SCK_IDLE: assert property (csN |-> !sck)
		else $error("serial clock moves outside a frame");
	AST_DEV_OE_CODE: assert property (devOe == 4'h0 || devOe == 4'h2 ||
		devOe == 4'hF)
		else $error("device drives an odd set of lines");
	AST_NO_CONTENTION: assert property ((devOe & hostOe) == 4'h0)
		else $error("both ends drive one line");
	AST_DEV_RELEASE: assert property (csN [*4] |-> devOe == 4'h0)
		else $error("device still drives after deselect");
	AST_PARAMS_STILL: assert property (!$stable(driveStrength) ||
		!$stable(wrapEnable) |-> csN)
		else $error("read parameters change inside a frame");
	AST_RESUME_FRAMED: assert property (resumeRequest |-> csN && !lowPower)
		else $error("resume issued inside a frame or asleep");
	AST_WAKE_BLOCKED: assert property (lowPower && writeInProgressFlag
		|=> lowPower)
		else $error("wake taken while a write runs");
	AST_SLEEP_ENTRY: assert property ($rose(lowPower) |->
		csN && riseCnt <= 8'(`SLEEP_ENTRY_CYCLES))
		else $error("sleep entered late or inside a frame");
	AST_WRAP_SLEEP: assert property (lowPower |-> !wrapEnable)
		else $error("wrap kept while asleep");
endmodule

// file: testbench.sv
// Bench joining host and flash ends over the link interface.
// Assumes both ends share mclk, arst_n and the mode line.
`timescale 1ns/1ns
`include "flash_cmd_consts.svh"
module testbench;
	localparam logic [7:0]  MAKER  = 8'h5A;    // arbitrary value
	localparam logic [7:0]  DEVICE = 8'hC6;    // arbitrary value
	localparam logic [15:0] TYPE   = 16'h1E2D; // arbitrary value
	logic        mclk   = 1'b0;
	logic        arst_n = 1'b0;
	logic        quad   = 1'b0;
	logic        write_in_progress_flag    = 1'b0;
	logic        susP   = 1'b0;
	logic        susE   = 1'b0;
	logic        start  = 1'b0;
	logic [7:0]  op     = 8'h00;
	logic [1:0]  argc   = 2'h0;
	logic [23:0] args   = 24'h00_0000;
	logic [2:0]  rdc    = 3'h0;
	logic        aLoad  = 1'b0;
	logic        aStep  = 1'b0;
	logic [23:0] aVal   = 24'h00_0000;
	logic        resumeSeen = 1'b0;
	logic        busy, rxValid, cmdDone, resumeReq, lowPower, wrapEnable;
	logic [7:0]  rxData;
	logic [3:0]  functionBits;
	logic [2:0]  driveStrength;
	logic [1:0]  burstSize;
	logic [23:0] readAddr;
	logic [7:0]  rxBuf [0:7];
	int          error_cnt = 0;
	int          cmp_count = 0;

	flash_link_if flash_link_if_i ();
	flash_cmd_host flash_cmd_host_i (.mclk(mclk), .arst_n(arst_n),
		.link(flash_link_if_i.host), .quadMode(quad), .cmdStart(start),
		.cmdOpcode(op), .cmdArgCount(argc), .cmdArgs(args),
		.cmdReadCount(rdc), .busy(busy), .rxData(rxData),
		.rxValid(rxValid), .cmdDone(cmdDone));
	flash_cmd_device #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE),
		.TYPE_CODE(TYPE)) flash_cmd_device_i (.mclk(mclk),
		.arst_n(arst_n), .link(flash_link_if_i.device), .quadMode(quad),
		.writeInProgressFlag(write_in_progress_flag), .suspendProgram(susP),
		.suspendErase(susE), .resumeRequest(resumeReq),
		.functionBits(functionBits), .lowPower(lowPower),
		.driveStrength(driveStrength), .wrapEnable(wrapEnable),
		.burstSize(burstSize), .addrLoad(aLoad), .addrLoadValue(aVal),
		.addrStep(aStep), .readAddr(readAddr));
	flash_cmd_chk flash_cmd_chk_i (.mclk(mclk), .arst_n(arst_n),
		.sck(flash_link_if_i.sck), .csN(flash_link_if_i.csN),
		.hostOe(flash_link_if_i.hostOe), .devOe(flash_link_if_i.devOe),
		.writeInProgressFlag(write_in_progress_flag), .resumeRequest(resumeReq),
		.lowPower(lowPower), .wrapEnable(wrapEnable),
		.driveStrength(driveStrength));

	always #(`MCLK_PERIOD_NS / 2) mclk = ~mclk;
	always @(posedge mclk)
		if (resumeReq === 1'b1)
			resumeSeen <= 1'b1;

	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// One whole command; read bytes land in rxBuf
	task automatic send(input logic [7:0] o, input logic [1:0] n,
			input logic [23:0] a, input logic [2:0] r);
		int k;
		int t;
		k = 0;
		@(posedge mclk);
		#5;
		op = o;
		argc = n;
		args = a;
		rdc = r;
		start = 1'b1;
		@(posedge mclk);
		#5;
		start = 1'b0;
		check(busy, 1'b1);
		for (t = 0; t < 3000 && cmdDone !== 1'b1; t++) begin
			@(posedge mclk);
			#1;
			if (rxValid === 1'b1) begin
				rxBuf[k[2:0]] = rxData;
				k++;
			end
		end
		if (cmdDone !== 1'b1) begin
			error_cnt++;
			report_and_stop();
		end
		check(busy, 1'b0);
		// Command takes effect a few cycles after deselect
		repeat (8) @(posedge mclk);
		#5;
	endtask

	task automatic addr(input logic ld, input logic [23:0] v,
			input logic [23:0] exp);
		@(posedge mclk);
		#5;
		aLoad = ld;
		aStep = !ld;
		aVal = v;
		@(posedge mclk);
		#5;
		aLoad = 1'b0;
		aStep = 1'b0;
		check(readAddr, exp);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check(driveStrength, `DRIVE_RESET);
		check(wrapEnable, 1'b0);
		check(functionBits, 4'h0);
	endtask

	task automatic t_ident();
		logic [7:0] seq [0:2];
		int m;
		int i;
		seq = '{MAKER, TYPE[15:8], TYPE[7:0]};
		for (m = 0; m < 2; m++) begin
			quad = m[0];
			send(m ? `OP_STD_ID_QUAD : `OP_STD_ID_SPI, 2'h0, 24'h00_0000, 3'h7);
			for (i = 0; i < 7; i++)
				check(rxBuf[i], seq[i % 3]);
		end
		quad = 1'b0;
	endtask

	task automatic t_codes();
		int i;
		int j;
		send(`OP_WAKE_ID, 2'h3, 24'h00_0000, 3'h4);
		for (j = 0; j < 4; j++)
			check(rxBuf[j], DEVICE);
		for (i = 0; i < 2; i++) begin
			send(`OP_MAKER_DEV_ID, 2'h3, {23'h00_0000, i[0]}, 3'h4);
			for (j = 0; j < 4; j++)
				check(rxBuf[j], (i[0] ^ j[0]) ? DEVICE : MAKER);
		end
	endtask

	task automatic t_params();
		int v;
		for (v = 0; v < 8; v++) begin
			send(`OP_SET_PARAMS, 2'h1, {v[2:0], 2'h0, v[2:0], 16'h0000}, 3'h0);
			check(driveStrength, v[2:0]);
			check(wrapEnable, v[2]);
			if (v[2])
				check(burstSize, v[1:0]);
		end
		// Opcode without its data byte must change nothing
		send(`OP_SET_PARAMS, 2'h0, 24'h00_0000, 3'h0);
		check(driveStrength, 3'h7);
		send(`OP_SET_PARAMS, 2'h1, 24'h04_0000, 3'h0);
		addr(1'b1, 24'h00_00FE, 24'h00_00FE);
		addr(1'b0, 24'h00_0000, 24'h00_00FF);
		addr(1'b0, 24'h00_0000, 24'h00_00F8);
	endtask

	task automatic t_resume();
		int i;
		for (i = 0; i < 2; i++) begin
			susP = !i[0];
			susE = i[0];
			@(posedge mclk);
			#5;
			susP = 1'b0;
			susE = 1'b0;
			repeat (2) @(posedge mclk);
			#5;
			check(functionBits, i[0] ? 4'h8 : 4'h4);
			resumeSeen = 1'b0;
			send(`OP_RESUME, 2'h0, 24'h00_0000, 3'h0);
			check(resumeSeen, 1'b1);
			check(functionBits, 4'h0);
		end
	endtask

	task automatic t_sleep();
		send(`OP_SLEEP, 2'h0, 24'h00_0000, 3'h0);
		repeat (`SLEEP_ENTRY_CYCLES + 20) @(posedge mclk);
		#5;
		check(lowPower, 1'b1);
		check(wrapEnable, 1'b0);
		send(`OP_STD_ID_SPI, 2'h0, 24'h00_0000, 3'h1);
		check(rxBuf[0], 24'h00_00FF);
		write_in_progress_flag = 1'b1;
		send(`OP_WAKE_ID, 2'h0, 24'h00_0000, 3'h0);
		check(lowPower, 1'b1);
		write_in_progress_flag = 1'b0;
		send(`OP_WAKE_ID, 2'h0, 24'h00_0000, 3'h0);
		repeat (20) @(posedge mclk);
		#5;
		check(lowPower, 1'b0);
		addr(1'b1, 24'h00_00FF, 24'h00_00FF);
		addr(1'b0, 24'h00_0000, 24'h00_0100);
	endtask

	initial begin
		repeat (4) @(posedge mclk);
		#5;
		arst_n = 1'b1;
		repeat (4) @(posedge mclk);
		#5;
		t_reset();
		t_ident();
		t_codes();
		t_params();
		t_resume();
		t_sleep();
		report_and_stop();
	end
endmodule
